// File: prom_prog_map.svh
`ifndef PROM_PROG_MAP_SVH
`define PROM_PROG_MAP_SVH

// Register offsets (byte addresses on AXI4-Lite)
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WDATA       8'h08
`define REG_RDATA       8'h0C
`define REG_ADDR        8'h10
`define REG_TIMING      8'h14

// Control register fields
`define CTRL_START_BIT  0
`define CTRL_READ_BIT   1
`define CTRL_ABORT_BIT  2

// Status register fields
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_ERR_BIT    2
`define STAT_SUPHI_BIT  3
`define STAT_RDV_BIT    4

// Mode codes on mode_select[3:0], bit 0 = first select pin
`define MODE_CLEAR      4'h5
`define MODE_WRITE      4'hE
`define MODE_VERIFY     4'hC
`define MODE_INHIBIT    4'hD
`define MODE_IDLE       4'h0

// Array geometry
`define LAST_ADDR       14'h3F7F
`define PULSES_PER_STEP 3'h4

// Timing in ns and derived cycles at 125 MHz
`define CLK_NS          8
`define SETTLE_NS       10000
`define WPULSE_NS       1000000
`define SETTLE_CYC      ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define WPULSE_CYC      (`WPULSE_NS / `CLK_NS)
`define HALF_CLK_CYC    32
`define MAX_TRIES       8'h19
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: prom_prog_pkg.sv
package prom_prog_pkg;

    typedef enum logic [3:0] {
        S_IDLE    = 4'b0000,
        S_POWER5  = 4'b0001,
        S_CLR0    = 4'b0010,
        S_RAISE   = 4'b0011,
        S_INH0    = 4'b0100,
        S_WRITE   = 4'b0101,
        S_INH1    = 4'b0110,
        S_VERIFY  = 4'b0111,
        S_OVER    = 4'b1000,
        S_INH2    = 4'b1001,
        S_STEP    = 4'b1010,
        S_CLRF    = 4'b1011,
        S_LOWER   = 4'b1100,
        S_OFF     = 4'b1101
    } seq_t;

    // Pins driven toward the device
    typedef struct packed {
        logic [3:0] mode;
        logic       clk;
        logic       clk_inv;
        logic       sup5;
        logic       suphi;
    } pins_t;

    // One byte with its location
    typedef struct packed {
        logic [13:0] addr;
        logic [7:0]  data;
    } byte_t;

endpackage

// File: prom_fifo.sv
`timescale 1ns/10ps
`include "prom_prog_map.svh"

// Flip-flop FIFO; ready on the filling side falls when full
module prom_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    // Honest flags from the occupancy count
    assign in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update
    always_comb
    begin
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop)
            cnt_nxt = cnt_r + 1'b1;
        else if (pop && !push)
            cnt_nxt = cnt_r - 1'b1;
    end

    // Registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end
endmodule

// File: prom_prog_ctrl.sv
`timescale 1ns/10ps
`include "prom_prog_map.svh"

// Function
// - Four mode pins pick clear, write, verify or inhibit.
// - Four clock pulses advance the address by one.
// - Byte travels as low nibble and high nibble ports.
// - Inverted clock pin carries the inverse of the clock pin.
// - Before power-up unused pins low and clock pin held low.
// - 5 V, wait 10 us, clear, raise supplies, then inhibit.
// - Write mode pulse of 1 ms with byte on nibbles, then inhibit.
// - Verify after each write; on mismatch retry, counting attempts.
// - After X attempts apply X times 1 ms extra write, then inhibit.
// - Repeat write, verify, overprogram, advance up to last address.
// - Finish with clear mode, supplies to 5 V, then power off.
module prom_prog_ctrl
    import prom_prog_pkg::*;
#(
    parameter int SETTLE_CYC = `SETTLE_CYC,
    parameter int WPULSE_CYC = `WPULSE_CYC,
    parameter int FDEPTH     = 8
)
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Supplies
    output logic             SUPPLY_ON,
    output logic             SUPPLY_HIGH,
    // Device pins
    output logic [3:0]       MODE_SELECT,
    output logic             PROG_CLOCK_IN,
    output logic             PROG_CLOCK_INV,
    output logic [3:0]       DATA_LOW_NIBBLE_O,
    output logic [3:0]       DATA_LOW_NIBBLE_OE,
    input  wire logic [3:0]  DATA_LOW_NIBBLE_I,
    output logic [3:0]       DATA_HIGH_NIBBLE_O,
    output logic [3:0]       DATA_HIGH_NIBBLE_OE,
    input  wire logic [3:0]  DATA_HIGH_NIBBLE_I
);
    seq_t        st_r, st_nxt;
    pins_t       pin_r, pin_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic [13:0] addr_r, addr_nxt, last_r, last_nxt;
    logic [7:0]  tries_r, tries_nxt, over_r, over_nxt;
    logic [2:0]  pls_r, pls_nxt;
    logic [7:0]  cur_r, cur_nxt, rd_r, rd_nxt;
    logic        rdmode_r, rdmode_nxt, done_r, done_nxt;
    logic        err_r, err_nxt, rdv_r, rdv_nxt, drv_r, drv_nxt;
    logic        start_p, abort_p;
    logic [7:0]  sy1_r, sy2_r, sy3_r, din_r, din_nxt;
    // FIFO wires
    logic        f_ready, f_valid, f_pop;
    logic [7:0]  f_data;
    logic        f_push;
    // Bus state
    logic        aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
    logic [7:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rdat_r, rdat_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;

    // Write data buffer: byte stream toward the array
    prom_fifo #(.WIDTH(8), .DEPTH(FDEPTH)) u_fifo
    (
        .clk       (CLK),
        .rst_b     (RST_B),
        .in_valid  (f_push),
        .in_ready  (f_ready),
        .in_data   (wd_r[7:0]),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    // Bus channel handshakes; a full FIFO stalls data writes
    assign S_AXI_AWREADY = !aw_r && !bv_r;
    assign S_AXI_WREADY  = !w_r && !bv_r;
    assign S_AXI_ARREADY = !rv_r;
    assign S_AXI_BVALID  = bv_r;
    assign S_AXI_BRESP   = br_r;
    assign S_AXI_RVALID  = rv_r;
    assign S_AXI_RRESP   = rr_r;
    assign S_AXI_RDATA   = rdat_r;
    wire wr_go = aw_r && w_r && !bv_r
                 && (awa_r != `REG_WDATA || f_ready);
    assign f_push  = wr_go && awa_r == `REG_WDATA && wd_r[31] == 1'b0;
    assign start_p = wr_go && awa_r == `REG_CTRL && wd_r[`CTRL_START_BIT];
    assign abort_p = wr_go && awa_r == `REG_CTRL && wd_r[`CTRL_ABORT_BIT];

    // Bus slave next state; last address and mode held in registers
    always_comb
    begin
        aw_nxt   = aw_r;
        w_nxt    = w_r;
        awa_nxt  = awa_r;
        wd_nxt   = wd_r;
        bv_nxt   = bv_r && !S_AXI_BREADY;
        br_nxt   = br_r;
        rv_nxt   = rv_r && !S_AXI_RREADY;
        rr_nxt   = rr_r;
        rdat_nxt = rdat_r;
        last_nxt = last_r;
        rdmode_nxt = rdmode_r;
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_nxt  = 1'b1;
            awa_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_nxt  = 1'b1;
            wd_nxt = S_AXI_WDATA;
        end
        if (wr_go)
        begin
            aw_nxt = 1'b0;
            w_nxt  = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = `RESP_OKAY;
            unique case (awa_r)
                `REG_CTRL:
                    if (st_r == S_IDLE)
                        rdmode_nxt = wd_r[`CTRL_READ_BIT];
                `REG_WDATA: ;
                `REG_ADDR:
                    last_nxt = (wd_r[13:0] > `LAST_ADDR) ? `LAST_ADDR
                                                        : wd_r[13:0];
                default: br_nxt = `RESP_SLVERR;
            endcase
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            rv_nxt   = 1'b1;
            rr_nxt   = `RESP_OKAY;
            rdat_nxt = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                `REG_CTRL:   rdat_nxt[1] = rdmode_r;
                `REG_STATUS: rdat_nxt[4:0] = {rdv_r, pin_r.suphi, err_r,
                                             done_r, st_r != S_IDLE};
                `REG_RDATA:  rdat_nxt[7:0] = rd_r;
                `REG_ADDR:   rdat_nxt = {2'h0, addr_r, 2'h0, last_r};
                `REG_TIMING: rdat_nxt = {tries_r, 24'h00_0000};
                default:     rr_nxt = `RESP_SLVERR;
            endcase
        end
    end

    // Data input: three-stage sync, accept when stages two and three agree
    always_comb
    begin
        din_nxt = (sy2_r == sy3_r) ? sy3_r : din_r;
    end

    // Programming sequence next state
    always_comb
    begin
        st_nxt    = st_r;
        pin_nxt   = pin_r;
        tmr_nxt   = (tmr_r != 32'h0) ? tmr_r - 1'b1 : tmr_r;
        addr_nxt  = addr_r;
        tries_nxt = tries_r;
        over_nxt  = over_r;
        pls_nxt   = pls_r;
        cur_nxt   = cur_r;
        rd_nxt    = rd_r;
        done_nxt  = done_r && !start_p;
        err_nxt   = err_r && !start_p;
        rdv_nxt   = rdv_r && !(S_AXI_ARVALID && S_AXI_ARREADY
                               && S_AXI_ARADDR == `REG_RDATA);
        drv_nxt   = 1'b0;
        f_pop     = 1'b0;
        pin_nxt.clk_inv = !pin_nxt.clk;
        unique case (st_r)
            S_IDLE:
                if (start_p)
                begin
                    pin_nxt.clk  = 1'b0;
                    pin_nxt.sup5 = 1'b1;
                    pin_nxt.mode = `MODE_IDLE;
                    tmr_nxt      = 32'(SETTLE_CYC);
                    st_nxt       = S_POWER5;
                end
            S_POWER5:
                if (tmr_r == 32'h0)
                begin
                    // clear after the 10 us wait
                    // clear mode zeroes the device counter
                    pin_nxt.mode = `MODE_CLEAR;
                    addr_nxt     = 14'h0000;
                    tmr_nxt      = 32'(`HALF_CLK_CYC);
                    st_nxt       = S_RAISE;
                end
            S_RAISE:
                if (tmr_r == 32'h0)
                begin
                    // raise to 6 V and 12.5 V
                    pin_nxt.suphi = 1'b1;
                    tmr_nxt       = 32'(SETTLE_CYC);
                    st_nxt        = S_INH0;
                end
            S_INH0:
                if (tmr_r == 32'h0)
                begin
                    pin_nxt.mode = `MODE_INHIBIT;
                    tries_nxt    = 8'h00;
                    tmr_nxt      = 32'(`HALF_CLK_CYC);
                    st_nxt       = rdmode_r ? S_INH1 : S_WRITE;
                end
            S_WRITE:
                begin
                    // 1 ms write pulse with byte on nibbles
                    drv_nxt = 1'b1;
                    if (pin_r.mode != `MODE_WRITE)
                    begin
                        if (tmr_r == 32'h0 && (f_valid || tries_r != 0))
                        begin
                            if (tries_r == 8'h00)
                            begin
                                cur_nxt = f_data;
                                f_pop   = 1'b1;
                            end
                            // Timer counts through zero: load one less
                            pin_nxt.mode = `MODE_WRITE;
                            tmr_nxt      = 32'(WPULSE_CYC - 1);
                            tries_nxt    = tries_r + 1'b1;
                        end
                        drv_nxt = f_valid || tries_r != 0;
                    end
                    else if (tmr_r == 32'h0)
                    begin
                        pin_nxt.mode = `MODE_INHIBIT;
                        tmr_nxt      = 32'(`HALF_CLK_CYC);
                        st_nxt       = S_INH1;
                    end
                end
            S_INH1:
                if (tmr_r == 32'h0)
                begin
                    pin_nxt.mode = `MODE_VERIFY;
                    tmr_nxt      = 32'(`HALF_CLK_CYC);
                    st_nxt       = S_VERIFY;
                end
            S_VERIFY:
                if (tmr_r == 32'h0)
                begin
                    if (rdmode_r)
                    begin
                        rd_nxt  = din_r;
                        rdv_nxt = 1'b1;
                        st_nxt  = S_STEP;
                    end
                    else if (din_r != cur_r)
                    begin
                        if (tries_r == `MAX_TRIES)
                        begin
                            err_nxt = 1'b1;
                            st_nxt  = S_CLRF;
                        end
                        else
                        begin
                            pin_nxt.mode = `MODE_INHIBIT;
                            st_nxt       = S_WRITE;
                        end
                    end
                    else
                    begin
                        // overprogram X times 1 ms
                        // Drive the byte from the first extra write cycle
                        over_nxt     = tries_r;
                        drv_nxt      = 1'b1;
                        pin_nxt.mode = `MODE_WRITE;
                        tmr_nxt      = 32'(WPULSE_CYC - 1);
                        st_nxt       = S_OVER;
                    end
                end
            S_OVER:
                begin
                    drv_nxt = 1'b1;
                    if (tmr_r == 32'h0)
                    begin
                        if (over_r > 8'h01)
                        begin
                            over_nxt = over_r - 1'b1;
                            tmr_nxt  = 32'(WPULSE_CYC - 1);
                        end
                        else
                        begin
                            pin_nxt.mode = `MODE_INHIBIT;
                            tmr_nxt      = 32'(`HALF_CLK_CYC);
                            st_nxt       = S_INH2;
                        end
                    end
                end
            S_INH2:
                if (tmr_r == 32'h0)
                    st_nxt = S_STEP;
            S_STEP:
                if (tmr_r == 32'h0)
                begin
                    // four clock pulses per address step
                    tmr_nxt     = 32'(`HALF_CLK_CYC);
                    pin_nxt.clk = !pin_r.clk;
                    pin_nxt.clk_inv = pin_r.clk;
                    if (pin_r.clk)
                    begin
                        pls_nxt = pls_r + 1'b1;
                        if (pls_r == `PULSES_PER_STEP - 3'h1)
                        begin
                            pls_nxt   = 3'h0;
                            addr_nxt  = addr_r + 1'b1;
                            tries_nxt = 8'h00;
                            if (addr_r == last_r)
                                st_nxt = S_CLRF;
                            else
                                st_nxt = rdmode_r ? S_VERIFY : S_WRITE;
                            if (rdmode_r)
                                pin_nxt.mode = `MODE_VERIFY;
                        end
                    end
                end
            S_CLRF:
                begin
                    pin_nxt.mode = `MODE_CLEAR;
                    tmr_nxt      = 32'(`HALF_CLK_CYC);
                    st_nxt       = S_LOWER;
                end
            S_LOWER:
                if (tmr_r == 32'h0)
                begin
                    pin_nxt.suphi = 1'b0;
                    tmr_nxt       = 32'(SETTLE_CYC);
                    st_nxt        = S_OFF;
                end
            S_OFF:
                if (tmr_r == 32'h0)
                begin
                    pin_nxt  = '{mode: `MODE_IDLE, clk: 1'b0, clk_inv: 1'b1,
                                 sup5: 1'b0, suphi: 1'b0};
                    done_nxt = 1'b1;
                    st_nxt   = S_IDLE;
                end
            default: st_nxt = S_IDLE;
        endcase
        // Abort goes through the orderly power-down
        if (abort_p && st_r != S_IDLE && st_r != S_CLRF
            && st_r != S_LOWER && st_r != S_OFF)
        begin
            err_nxt = 1'b1;
            st_nxt  = S_CLRF;
        end
    end

    // Pin outputs come from flip-flops
    assign MODE_SELECT         = pin_r.mode;
    assign PROG_CLOCK_IN       = pin_r.clk;
    assign PROG_CLOCK_INV      = pin_r.clk_inv;
    assign SUPPLY_ON           = pin_r.sup5;
    assign SUPPLY_HIGH         = pin_r.suphi;
    assign DATA_LOW_NIBBLE_O   = cur_r[3:0];
    assign DATA_HIGH_NIBBLE_O  = cur_r[7:4];
    assign DATA_LOW_NIBBLE_OE  = {4{drv_r}};
    assign DATA_HIGH_NIBBLE_OE = {4{drv_r}};

    // All registers
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_r <= S_IDLE;
            pin_r <= '{mode: `MODE_IDLE, clk: 1'b0, clk_inv: 1'b1,
                       sup5: 1'b0, suphi: 1'b0};
            tmr_r <= 32'h0;  addr_r <= 14'h0;  last_r <= `LAST_ADDR;
            tries_r <= 8'h0; over_r <= 8'h0;   pls_r <= 3'h0;
            cur_r <= 8'h0;   rd_r <= 8'h0;     rdmode_r <= 1'b0;
            done_r <= 1'b0;  err_r <= 1'b0;    rdv_r <= 1'b0;
            drv_r <= 1'b0;   sy1_r <= 8'h0;    sy2_r <= 8'h0;
            sy3_r <= 8'h0;   din_r <= 8'h0;    aw_r <= 1'b0;
            w_r <= 1'b0;     bv_r <= 1'b0;     rv_r <= 1'b0;
            awa_r <= 8'h0;   wd_r <= 32'h0;    rdat_r <= 32'h0;
            br_r <= 2'h0;    rr_r <= 2'h0;
        end
        else
        begin
            st_r <= st_nxt;  pin_r <= pin_nxt; tmr_r <= tmr_nxt;
            addr_r <= addr_nxt; last_r <= last_nxt;
            tries_r <= tries_nxt; over_r <= over_nxt; pls_r <= pls_nxt;
            cur_r <= cur_nxt; rd_r <= rd_nxt;  rdmode_r <= rdmode_nxt;
            done_r <= done_nxt; err_r <= err_nxt; rdv_r <= rdv_nxt;
            drv_r <= drv_nxt;
            sy1_r <= {DATA_HIGH_NIBBLE_I, DATA_LOW_NIBBLE_I};
            sy2_r <= sy1_r;  sy3_r <= sy2_r;   din_r <= din_nxt;
            aw_r <= aw_nxt;  w_r <= w_nxt;     bv_r <= bv_nxt;
            rv_r <= rv_nxt;  awa_r <= awa_nxt; wd_r <= wd_nxt;
            rdat_r <= rdat_nxt; br_r <= br_nxt; rr_r <= rr_nxt;
        end
    end
endmodule

// File: prom_prog_asserts.sv
`timescale 1ns/10ps
`include "prom_prog_map.svh"
// Pin sequence checks toward the device
module prom_prog_asserts
(
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RST_B,
    // Device pins
    input wire logic [3:0] MODE_SELECT,
    input wire logic       PROG_CLOCK_IN,
    input wire logic       PROG_CLOCK_INV,
    input wire logic       SUPPLY_ON,
    input wire logic       SUPPLY_HIGH
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Bench pulse is 8 cycles; real pulses are far longer
    sequence s_wr;
        (MODE_SELECT == `MODE_WRITE)[*8];
    endsequence
    sequence s_hi;
        PROG_CLOCK_IN[*8];
    endsequence
    AST_CLK_INV: assert property
        (PROG_CLOCK_INV != PROG_CLOCK_IN) else $error("clock pair");
    AST_WR_HI: assert property
        (MODE_SELECT == `MODE_WRITE |-> SUPPLY_HIGH) else $error("low wr");
    AST_OFF_LOW: assert property
        (!SUPPLY_ON |-> !PROG_CLOCK_IN) else $error("clock unpowered");
    AST_WR_LEN: assert property
        ($rose(MODE_SELECT == `MODE_WRITE) |-> s_wr) else $error("short wr");
    AST_HALF: assert property
        ($rose(PROG_CLOCK_IN) |-> s_hi) else $error("short clock");
    AST_NO_WR_STEP: assert property
        (PROG_CLOCK_IN |-> MODE_SELECT != `MODE_WRITE) else $error("step");
    AST_HI_CLR: assert property
        ($rose(SUPPLY_HIGH) |-> MODE_SELECT == `MODE_CLEAR) else $error("up");
    AST_LOW_CLR: assert property
        ($fell(SUPPLY_HIGH) |-> MODE_SELECT == `MODE_CLEAR) else $error("dn");
endmodule
bind prom_prog_ctrl prom_prog_asserts prom_prog_asserts_i (.CLK(CLK),
    .RST_B(RST_B), .MODE_SELECT(MODE_SELECT), .SUPPLY_ON(SUPPLY_ON),
    .PROG_CLOCK_IN(PROG_CLOCK_IN), .PROG_CLOCK_INV(PROG_CLOCK_INV),
    .SUPPLY_HIGH(SUPPLY_HIGH));

// File: prom_dev_model.sv
`timescale 1ns/10ps
`include "prom_prog_map.svh"
// Erased cells read FF and writes only clear bits; cell 1 needs two pulses
module prom_dev_model
(
    // Pins from the programmer
    input  wire logic       clk,
    input  wire logic       sup_hi,
    input  wire logic       pclk,
    input  wire logic [3:0] mode,
    input  wire logic [7:0] din,
    // Verify data; pull-downs win when idle
    output logic      [7:0] dout
);
    logic [7:0]  mem [0:16255] = '{default: 8'hFF};
    int          wcyc [0:7] = '{default: 0};
    logic [13:0] addr = 14'h0;
    logic [1:0]  pcnt = 2'h0;
    logic        pclk_d = 1'b0;
    always @(posedge clk)
    begin
        pclk_d <= pclk;
        if (mode == `MODE_CLEAR)
            {addr, pcnt} <= 16'h0;
        else if (sup_hi && pclk && !pclk_d)
            {addr, pcnt} <= {addr, pcnt} + 16'h1;
        if (sup_hi && mode == `MODE_WRITE)
        begin
            wcyc[addr[2:0]] <= wcyc[addr[2:0]] + 1;
            if (addr != 14'h1 || wcyc[1] >= 8)
                mem[addr] <= mem[addr] & din;
        end
    end
    assign dout = (sup_hi && mode == `MODE_VERIFY) ? mem[addr] : 8'h00;
endmodule

// File: prom_prog_ctrl_tb.sv
`timescale 1ns/10ps
`include "prom_prog_map.svh"
module prom_prog_ctrl_tb;
    localparam int WP = 8;
    logic        clk = 0, rst_b = 0, awv = 0, wv = 0, bready = 0;
    logic        arv = 0, rready = 0, aw_rdy, w_rdy, bv, arr, rv, shi, pck;
    logic [7:0]  awa = 0, ara = 0, dout;
    logic [31:0] wd = 0, rdat, d, sd = 32'h83045641;
    logic [1:0]  rsp, r;
    logic [3:0]  md, lo, loe, hi, hie, li, hv;
    logic [7:0]  q[$];
    int          fail_count = 0, tests_run = 0, cyc = 0;
    // Nibble wires: programmer wins where enabled
    assign li = (loe & lo) | (~loe & dout[3:0]);
    assign hv = (hie & hi) | (~hie & dout[7:4]);
    always #4 clk = ~clk;
    prom_prog_ctrl #(.SETTLE_CYC(4), .WPULSE_CYC(WP)) prom_prog_ctrl_i (
        .CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rsp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .SUPPLY_ON(), .SUPPLY_HIGH(shi), .MODE_SELECT(md),
        .PROG_CLOCK_IN(pck), .PROG_CLOCK_INV(), .DATA_LOW_NIBBLE_O(lo),
        .DATA_LOW_NIBBLE_OE(loe), .DATA_LOW_NIBBLE_I(li),
        .DATA_HIGH_NIBBLE_O(hi), .DATA_HIGH_NIBBLE_OE(hie),
        .DATA_HIGH_NIBBLE_I(hv));
    prom_dev_model prom_dev_model_i (.clk(clk), .sup_hi(shi), .pclk(pck),
        .mode(md), .din({hv, li}), .dout(dout));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic pa = 1, pw = 1;
        awa <= a;
        wd <= v;
        awv <= 1;
        wv <= 1;
        while (pa || pw)
        begin
            @(posedge clk);
            pa = pa && !aw_rdy;
            pw = pw && !w_rdy;
            awv <= pa;
            wv <= pw;
        end
        do @(posedge clk); while (!bv);
        bready <= 1;
        @(posedge clk);
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        ara <= a;
        arv <= 1;
        do @(posedge clk); while (!arr);
        arv <= 0;
        rready <= 1;
        do @(posedge clk); while (!rv);
        d = rdat;
        r = rsp;
        rready <= 0;
    endtask
    // Start and poll until done
    task automatic run(input logic [31:0] ctl);
        wr(8'h00, ctl);
        do rd(8'h04); while (d[1] !== 1'b1);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Hang guard; the run needs well under this
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fail_count++;
            close_out();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1;
        for (int i = 0; i < 8; i++)
        begin
            sd = xs(sd);
            q.push_back(i == 1 ? sd[7:0] & 8'hFE : sd[7:0]);
        end
        // Fill the whole FIFO before starting
        wr(8'h10, 32'h7);
        foreach (q[i]) wr(8'h08, {24'h0, q[i]});
        run(32'h1);
        // slow cell retried, overwrite scales with tries
        chk(d[2], 1'b0);
        foreach (q[i])
        begin
            chk(prom_dev_model_i.mem[i], q[i]);
            chk(prom_dev_model_i.wcyc[i], (i == 1 ? 4 : 2) * WP);
        end
        // read walk leaves the last byte
        run(32'h3);
        rd(8'h0C);
        chk(d[7:0], q[7]);
        wr(8'h10, 32'hFFFF);
        rd(8'h10);
        chk(d[13:0], 14'h3F7F);
        // Abort early in the sequence still ends with clear and power-down
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h4);
        do rd(8'h04); while (d[1] !== 1'b1);
        chk(d[4:0], 5'h06);
        rd(8'h1C);
        chk(r, `RESP_SLVERR);
        close_out();
    end
endmodule
